// >>> bench/tb_ddc_nco_standby_config.sv
// testbench for the downconversion configuration bank: reset values, decimation, profile words,
// sync phase load, output format, standby mask and the calibration abort sequence
// assumes the bank's own assertions sit in the design files; inputs change on falling edges
`timescale 1ns/10ps
`default_nettype none

module tb_ddc_nco_standby_config
  import ddc_nco_pkg::*;
;
  localparam int SIM_WAIT = 20;
  localparam logic [7:0] PMASK [5] = '{8'h3f, 8'hff, 8'h3f, 8'hff, 8'h03};
  localparam logic [5:0] DEC_EXP [8] = '{6'h00, 6'h20, 6'h18, 6'h10, 6'h0c, 6'h00, 6'h00, 6'h00};
  logic i_clk, i_rst, i_reg_wr, i_reg_rd, i_cal_busy, i_cal_finish, i_sysref_sync, i_standby;
  logic [ADDR_W-1:0] i_reg_addr;
  logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata;
  logic [PROFILE_W-1:0] i_profile_sel;
  logic o_reg_rvalid, o_cal_abort, o_cal_cmd_clear, o_cal_overdue, o_fine_step_3072;
  logic o_fine_shift_down, o_fine_shift_up, o_phase_load, o_offset_binary;
  logic [5:0] o_decim_factor;
  logic [COARSE_W-1:0] o_coarse_tuning, o_coarse_start_phase, o_coarse_phase;
  logic [FINE_W-1:0] o_fine_tuning;
  logic [FINE_START_W-1:0] o_fine_start_phase;
  wire logic [6:0] stby;
  logic [7:0] exp_q [$];
  logic [7:0] pw [4][5];
  logic [6:0] m;
  int failures = 0;
  int checked = 0;
  int na, nc, n;

  ddc_nco_standby_config #(.CAL_WAIT(SIM_WAIT)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_cal_busy(i_cal_busy), .i_cal_finish(i_cal_finish),
    .o_cal_abort(o_cal_abort), .o_cal_cmd_clear(o_cal_cmd_clear), .o_cal_overdue(o_cal_overdue),
    .i_profile_sel(i_profile_sel), .i_sysref_sync(i_sysref_sync), .o_decim_factor(o_decim_factor),
    .o_fine_step_3072(o_fine_step_3072), .o_coarse_tuning(o_coarse_tuning),
    .o_fine_tuning(o_fine_tuning), .o_fine_shift_down(o_fine_shift_down),
    .o_fine_shift_up(o_fine_shift_up), .o_coarse_start_phase(o_coarse_start_phase),
    .o_fine_start_phase(o_fine_start_phase), .o_phase_load(o_phase_load),
    .o_coarse_phase(o_coarse_phase), .o_offset_binary(o_offset_binary), .i_standby(i_standby),
    .o_standby_neg_supply_off(stby[6]), .o_standby_main_pll_off(stby[5]),
    .o_standby_link_pll_off(stby[4]), .o_standby_link_tx_off(stby[3]),
    .o_standby_framer_off(stby[2]), .o_standby_datapath_off(stby[1]),
    .o_standby_digital_clocks_off(stby[0])
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_out(input logic [9:0] got, input logic [9:0] e);
    checked++;
    if (got !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic check_reg(input logic [7:0] got, input logic [7:0] e);
    checked++;
    if (got !== e) begin
      failures++;
      $display("wrong value at %0t: read %h expected %h", $time, got, e);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge i_clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  // expected data is queued here and compared when the read answer shows up
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    exp_q.push_back(e);
    @(negedge i_clk);
    i_reg_rd = 1'b0;
  endtask

  // abort and clear pulses counted from now, so a pulse already up is not missed
  task automatic count_cal(output int ca, output int cc);
    ca = 0;
    cc = 0;
    repeat (4) begin
      ca += (o_cal_abort === 1'b1);
      cc += (o_cal_cmd_clear === 1'b1);
      @(negedge i_clk);
    end
  endtask

  // sampled mid-cycle, clear of the edge that launches the answer
  always @(negedge i_clk) begin
    if (o_reg_rvalid === 1'b1) begin
      check_reg(o_reg_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    repeat (6000) @(posedge i_clk);
    failures++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, i_cal_busy, i_cal_finish, i_sysref_sync, i_standby} = 7'h40;
    i_reg_addr = 10'h000;
    i_reg_wdata = 8'h00;
    i_profile_sel = 2'h0;
    void'($urandom(32'ha0b1954a));
    idle(12);
    i_rst = 1'b0;
    rd(ADDR_DECIM, 8'h01);
    rd(ADDR_COARSE_TUNE, 8'h05);
    rd(ADDR_FINE_TUNE, 8'h15);
    rd(ADDR_COARSE_START, 8'h00);
    rd(ADDR_FINE_START_LOW, 8'h00);
    rd(ADDR_FINE_START_HIGH, 8'h00);
    rd(ADDR_OUT_FORMAT, 8'h00);
    rd(ADDR_STANDBY, 8'h02);
    rd(ADDR_CAL_ABORT, 8'h00);
    rd(10'h100, 8'h00);
    check_out(10'(o_decim_factor), 10'h020);
    check_out(10'(o_coarse_tuning), 10'h005);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 5; k++) pw[p][k] = 8'($urandom);
    end
    pw[2][1] = 8'h00;
    pw[3][1] = 8'h80;
    for (int p = 1; p < 4; p++) begin
      i_profile_sel = 2'(p);
      idle(3);
      rd(ADDR_COARSE_TUNE, 8'h00);
      check_out(10'(o_coarse_tuning), 10'h000);
      for (int k = 0; k < 5; k++) wr(ADDR_COARSE_TUNE + 10'(k), pw[p][k]);
    end
    i_profile_sel = 2'h0;
    idle(3);
    for (int k = 0; k < 5; k++) wr(ADDR_COARSE_TUNE + 10'(k), pw[0][k]);
    for (int p = 3; p >= 0; p--) begin
      i_profile_sel = 2'(p);
      idle(3);
      for (int k = 0; k < 5; k++) rd(ADDR_COARSE_TUNE + 10'(k), pw[p][k] & PMASK[k]);
      check_out(10'(o_coarse_tuning), 10'(pw[p][0] & 8'h3f));
      check_out(10'(o_fine_tuning), 10'(pw[p][1]));
      check_out(10'(o_coarse_start_phase), 10'(pw[p][2] & 8'h3f));
      check_out(o_fine_start_phase, {pw[p][4][1:0], pw[p][3]});
      check_out(10'({o_fine_shift_down, o_fine_shift_up}), 10'({$signed(pw[p][1]) > 0, pw[p][1][7]}));
    end
    // profile 0 stays selected for the sync load
    @(negedge i_clk);
    i_sysref_sync = 1'b1;
    @(negedge i_clk);
    i_sysref_sync = 1'b0;
    n = 0;
    while (o_phase_load !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    check_out(10'(o_phase_load), 10'h001);
    check_out(10'(o_coarse_phase), 10'(pw[0][2] & 8'h3f));
    @(negedge i_clk);
    check_out(10'(o_phase_load), 10'h000);
    check_out(10'(o_coarse_phase), 10'(6'(pw[0][2] + pw[0][0])));
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_DECIM, 8'(c));
      rd(ADDR_DECIM, 8'(c));
      idle(1);
      check_out(10'(o_decim_factor), 10'(DEC_EXP[c]));
      check_out(10'(o_fine_step_3072), 10'(c == 2 || c == 4));
    end
    wr(ADDR_OUT_FORMAT, 8'hff);
    rd(ADDR_OUT_FORMAT, 8'h01);
    check_out(10'(o_offset_binary), 10'h001);
    wr(ADDR_OUT_FORMAT, 8'h00);
    idle(2);
    check_out(10'(o_offset_binary), 10'h000);
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 7'h01 : (i == 1) ? 7'h7e : 7'($urandom);
      wr(ADDR_STANDBY, {1'b0, m});
      idle(2);
      check_out(10'(stby), 10'h000);
      i_standby = 1'b1;
      idle(2);
      check_out(10'(stby), 10'(m));
      i_standby = 1'b0;
      idle(2);
    end
    // a write to the abort register outside calibration is dropped
    wr(ADDR_CAL_ABORT, 8'h01);
    rd(ADDR_CAL_ABORT, 8'h00);
    wr(ADDR_CAL_ABORT, 8'h00);
    count_cal(na, nc);
    check_out(10'(na), 10'h000);
    i_cal_busy = 1'b1;
    wr(ADDR_CAL_ABORT, 8'h01);
    rd(ADDR_CAL_ABORT, 8'h01);
    wr(ADDR_CAL_ABORT, 8'h00);
    count_cal(na, nc);
    check_out(10'({na[4:0], nc[4:0]}), 10'h021);
    i_cal_busy = 1'b0;
    idle(2);
    i_cal_busy = 1'b1;
    wr(ADDR_CAL_ABORT, 8'h01);
    i_cal_busy = 1'b0;
    idle(2);
    i_cal_busy = 1'b1;
    wr(ADDR_CAL_ABORT, 8'h00);
    count_cal(na, nc);
    check_out(10'(na), 10'h000);
    i_cal_busy = 1'b0;
    idle(2);
    i_cal_busy = 1'b1;
    idle(1);
    i_cal_finish = 1'b1;
    @(negedge i_clk);
    i_cal_finish = 1'b0;
    count_cal(na, nc);
    check_out(10'({na[4:0], nc[4:0]}), 10'h001);
    i_cal_busy = 1'b0;
    idle(2);
    i_cal_busy = 1'b1;
    idle(10);
    check_out(10'(o_cal_overdue), 10'h000);
    idle(15);
    check_out(10'(o_cal_overdue), 10'h001);
    i_cal_busy = 1'b0;
    idle(3);
    check_out(10'(o_cal_overdue), 10'h000);
    if (exp_q.size() != 0) failures++;
    give_verdict();
  end
endmodule // tb_ddc_nco_standby_config
`default_nettype wire

// >>> rtl/ddc_nco_pkg.sv
// constants for the downconversion configuration bank: offsets, resets, fields, states
// assumes a register port that already decodes serial frames into byte accesses
//
// Contract
// (R1) abort: software writes abort bit one then zero; device stops calibration, frees port
// (R2) host aborts only if calibration command stays set beyond 400 ms
// (R3) abort register reachable only while the controller runs a calibration
// (R4) decimation code 1,2,3,4 gives factor 32,24,16,12; reset 0x01
// (R5) coarse frequency is six-bit word times sample rate over 64
// (R6) fine word is signed; step rate/4096 in modes 1,3, rate/3072 in 2,4
// (R7) positive fine word shifts down, negative shifts up
// (R8) tuning and phase registers exist once per profile; coarse reset 0x05 profile 0
// (R9) coarse oscillator loads six-bit start phase on sysref sync
// (R10) fine start phase is ten bits, low eight and top two in two registers
// (R11) format bit clear gives twos complement, set gives offset binary
// (R12) in standby, blocks with mask bit set power down, others stay active
// (R13) mask bits: 6 neg supply, 5 main pll, 4 link pll, 3 link tx, 2 framer, 1 datapath
// (R14) mask bit 0 gates all digital clocks during standby
// (R15) calibration command clears on finish and on completed abort
// (R16) two-bit profile select chooses the active profile
// (R17) datapath and register accesses both use the selected profile's copies

package ddc_nco_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  localparam logic [9:0] ADDR_CAL_ABORT = 10'h11a;
  localparam logic [9:0] ADDR_DECIM = 10'h140;
  localparam logic [9:0] ADDR_COARSE_TUNE = 10'h141;
  localparam logic [9:0] ADDR_FINE_TUNE = 10'h142;
  localparam logic [9:0] ADDR_COARSE_START = 10'h143;
  localparam logic [9:0] ADDR_FINE_START_LOW = 10'h144;
  localparam logic [9:0] ADDR_FINE_START_HIGH = 10'h145;
  localparam logic [9:0] ADDR_OUT_FORMAT = 10'h146;
  localparam logic [9:0] ADDR_STANDBY = 10'h150;

  localparam logic [2:0] RST_DECIM = 3'h1;
  localparam logic RST_OUT_FORMAT = 1'h0;
  localparam logic [6:0] RST_STANDBY = 7'h02;

  localparam int CAL_ABORT_BIT = 0;
  localparam int OFFSET_BINARY_BIT = 0;

  // standby mask bit positions
  localparam int STANDBY_DIGITAL_CLOCKS_OFF_BIT = 0;
  localparam int STANDBY_DATAPATH_OFF_BIT = 1;
  localparam int STANDBY_FRAMER_OFF_BIT = 2;
  localparam int STBY_LINK_TX_BIT = 3;
  localparam int STBY_LINK_PLL_BIT = 4;
  localparam int STBY_MAIN_PLL_BIT = 5;
  localparam int STBY_NEG_SUPPLY_BIT = 6;
  localparam int STBY_W = 7;

  localparam logic [2:0] DEC_CODE_32 = 3'h1;
  localparam logic [2:0] DEC_CODE_24 = 3'h2;
  localparam logic [2:0] DEC_CODE_16 = 3'h3;
  localparam logic [2:0] DEC_CODE_12 = 3'h4;
  localparam logic [5:0] DEC_FACTOR_32 = 6'h20;
  localparam logic [5:0] DEC_FACTOR_24 = 6'h18;
  localparam logic [5:0] DEC_FACTOR_16 = 6'h10;
  localparam logic [5:0] DEC_FACTOR_12 = 6'h0c;
  localparam logic [5:0] DEC_FACTOR_NONE = 6'h00;

  // one profile entry: coarse tune, fine tune, coarse start, fine start
  localparam int PROFILES = 4;
  localparam int PROFILE_W = 2;
  localparam int COARSE_W = 6;
  localparam int FINE_W = 8;
  localparam int FINE_START_W = 10;
  localparam int COARSE_TUNE_LSB = 0;
  localparam int FINE_TUNE_LSB = 6;
  localparam int COARSE_START_LSB = 14;
  localparam int FINE_START_LSB = 20;
  localparam int ENTRY_W = 30;
  localparam logic [29:0] ENTRY_RST_PROFILE0 = {10'h000, 6'h00, 8'h15, 6'h05};
  localparam logic [29:0] ENTRY_RST_OTHER = 30'h00000000;

  // calibration overdue watch
  localparam int CLK_HZ = 100000000;
  localparam int CAL_WAIT_MS = 400;
  localparam int CAL_WAIT_CYCLES = CAL_WAIT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    AB_IDLE = 3'b001,
    AB_ARMED = 3'b010,
    AB_FIRE = 3'b100
  } abort_state_t;

endpackage

// >>> rtl/ddc_nco_standby_config.sv
// configuration bank: calibration abort, decimation, per-profile oscillator words,
// output format and standby power mask
// assumes a byte-wide register port fed by the serial interface, inputs synchronous to i_clk
`timescale 1ns/10ps
`default_nettype none

module ddc_nco_standby_config
  import ddc_nco_pkg::*;
#(
  parameter int CAL_WAIT = CAL_WAIT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // calibration controller
  input wire logic i_cal_busy,
  input wire logic i_cal_finish,
  output logic o_cal_abort,
  output logic o_cal_cmd_clear,
  output logic o_cal_overdue,
  // profile and sync
  input wire logic [PROFILE_W-1:0] i_profile_sel,
  input wire logic i_sysref_sync,
  // datapath controls
  output logic [5:0] o_decim_factor,
  output logic o_fine_step_3072,
  output logic [COARSE_W-1:0] o_coarse_tuning,
  output logic [FINE_W-1:0] o_fine_tuning,
  output logic o_fine_shift_down,
  output logic o_fine_shift_up,
  output logic [COARSE_W-1:0] o_coarse_start_phase,
  output logic [FINE_START_W-1:0] o_fine_start_phase,
  output logic o_phase_load,
  output logic [COARSE_W-1:0] o_coarse_phase,
  output logic o_offset_binary,
  // standby
  input wire logic i_standby,
  output logic o_standby_neg_supply_off,
  output logic o_standby_main_pll_off,
  output logic o_standby_link_pll_off,
  output logic o_standby_link_tx_off,
  output logic o_standby_framer_off,
  output logic o_standby_datapath_off,
  output logic o_standby_digital_clocks_off
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic wr_cal, wr_profile;
  assign wr_cal = i_reg_wr && (i_reg_addr == ADDR_CAL_ABORT) && i_cal_busy; // see (R3)
  assign wr_profile = i_reg_wr && (i_reg_addr >= ADDR_COARSE_TUNE) && (i_reg_addr <= ADDR_FINE_START_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // calibration abort
  abort_state_t abort_state, next_abort_state;
  logic abort_bit, next_abort_bit;
  logic cmd_clear, next_cmd_clear;
  logic [31:0] cal_cnt, next_cal_cnt;
  logic overdue, next_overdue;

  always_comb begin
    next_abort_state = abort_state;
    next_abort_bit = abort_bit;
    next_cal_cnt = cal_cnt;
    next_overdue = overdue;
    // finish and completed abort both clear the command
    next_cmd_clear = i_cal_finish; // see (R15)
    case (abort_state)
      AB_IDLE: begin
        if (wr_cal && i_reg_wdata[CAL_ABORT_BIT]) begin
          next_abort_state = AB_ARMED; // see (R1)
        end
      end
      AB_ARMED: begin
        if (!i_cal_busy) begin
          next_abort_state = AB_IDLE;
        end else if (wr_cal && !i_reg_wdata[CAL_ABORT_BIT]) begin
          next_abort_state = AB_FIRE; // see (R1)
          next_cmd_clear = 1'b1; // see (R15)
        end
      end
      AB_FIRE: next_abort_state = AB_IDLE;
      default: next_abort_state = AB_IDLE;
    endcase
    // bit is meaningless once the controller stops, so it drops with busy
    if (wr_cal) begin
      next_abort_bit = i_reg_wdata[CAL_ABORT_BIT];
    end else if (!i_cal_busy) begin
      next_abort_bit = 1'b0;
    end
    // overdue flag only helps software decide when to abort
    if (!i_cal_busy) begin
      next_cal_cnt = 32'h0;
      next_overdue = 1'b0;
    end else if (cal_cnt >= 32'(CAL_WAIT - 1)) begin
      next_overdue = 1'b1; // see (R2)
    end else begin
      next_cal_cnt = cal_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      abort_state <= AB_IDLE;
      abort_bit <= 1'b0;
      cmd_clear <= 1'b0;
      cal_cnt <= 32'h0;
      overdue <= 1'b0;
    end else begin
      abort_state <= next_abort_state;
      abort_bit <= next_abort_bit;
      cmd_clear <= next_cmd_clear;
      cal_cnt <= next_cal_cnt;
      overdue <= next_overdue;
    end
  end

  assign o_cal_abort = abort_state[2];
  assign o_cal_cmd_clear = cmd_clear;
  assign o_cal_overdue = overdue;

  ////////////////////////////////////////////////////////////////////////////
  // profile copies
  logic [ENTRY_W-1:0] prof_rdata, prof_wdata;

  // read-merge-write into the selected profile; write-first store keeps it coherent
  always_comb begin
    prof_wdata = prof_rdata;
    case (i_reg_addr)
      ADDR_COARSE_TUNE: prof_wdata[COARSE_TUNE_LSB +: COARSE_W] = i_reg_wdata[COARSE_W-1:0];
      ADDR_FINE_TUNE: prof_wdata[FINE_TUNE_LSB +: FINE_W] = i_reg_wdata;
      ADDR_COARSE_START: prof_wdata[COARSE_START_LSB +: COARSE_W] = i_reg_wdata[COARSE_W-1:0];
      ADDR_FINE_START_LOW: prof_wdata[FINE_START_LSB +: 8] = i_reg_wdata; // see (R10)
      ADDR_FINE_START_HIGH: prof_wdata[FINE_START_LSB + 8 +: 2] = i_reg_wdata[1:0]; // see (R10)
      default: prof_wdata = prof_rdata;
    endcase
  end

  profile_word_store #(
    .WIDTH(ENTRY_W),
    .DEPTH(PROFILES),
    .AW(PROFILE_W),
    .RST_FIRST(ENTRY_RST_PROFILE0), // see (R8)
    .RST_REST(ENTRY_RST_OTHER)
  ) u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(wr_profile),
    .i_waddr(i_profile_sel), // see (R17)
    .i_wdata(prof_wdata),
    .i_raddr(i_profile_sel), // see (R16)
    .o_rdata(prof_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // plain control registers
  logic [2:0] decim, next_decim;
  logic offset_bin, next_offset_bin;
  logic [STBY_W-1:0] stby_mask, next_stby_mask;
  always_comb begin
    next_decim = decim;
    next_offset_bin = offset_bin;
    next_stby_mask = stby_mask;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_DECIM: next_decim = i_reg_wdata[2:0];
        ADDR_OUT_FORMAT: next_offset_bin = i_reg_wdata[OFFSET_BINARY_BIT];
        ADDR_STANDBY: next_stby_mask = i_reg_wdata[STBY_W-1:0];
        default: next_decim = decim;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      decim <= RST_DECIM; // see (R4)
      offset_bin <= RST_OUT_FORMAT;
      stby_mask <= RST_STANDBY; // see (R13)
    end else begin
      decim <= next_decim;
      offset_bin <= next_offset_bin;
      stby_mask <= next_stby_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath outputs
  logic [5:0] next_factor;
  logic next_step_3072;
  logic [FINE_W-1:0] fine_field;
  logic [COARSE_W-1:0] next_coarse_phase;
  logic [STBY_W-1:0] stby_out, next_stby_out;

  assign fine_field = prof_rdata[FINE_TUNE_LSB +: FINE_W];
  always_comb begin
    next_step_3072 = 1'b0;
    case (decim)
      DEC_CODE_32: next_factor = DEC_FACTOR_32; // see (R4)
      DEC_CODE_24: begin
        next_factor = DEC_FACTOR_24;
        next_step_3072 = 1'b1; // see (R6)
      end
      DEC_CODE_16: next_factor = DEC_FACTOR_16;
      DEC_CODE_12: begin
        next_factor = DEC_FACTOR_12;
        next_step_3072 = 1'b1; // see (R6)
      end
      default: next_factor = DEC_FACTOR_NONE;
    endcase
    // phase wraps in sixty-fourths of a cycle, one step per sample
    next_coarse_phase = i_sysref_sync ? prof_rdata[COARSE_START_LSB +: COARSE_W] // see (R9)
        : COARSE_W'(o_coarse_phase + o_coarse_tuning); // see (R5)
    next_stby_out = i_standby ? stby_mask : '0; // see (R12)
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_decim_factor <= DEC_FACTOR_32;
      o_fine_step_3072 <= 1'b0;
      o_coarse_tuning <= ENTRY_RST_PROFILE0[COARSE_TUNE_LSB +: COARSE_W];
      o_fine_tuning <= ENTRY_RST_PROFILE0[FINE_TUNE_LSB +: FINE_W];
      o_fine_shift_down <= 1'b0;
      o_fine_shift_up <= 1'b0;
      o_coarse_start_phase <= '0;
      o_fine_start_phase <= '0;
      o_phase_load <= 1'b0;
      o_coarse_phase <= '0;
      o_offset_binary <= RST_OUT_FORMAT;
      stby_out <= '0;
    end else begin
      o_decim_factor <= next_factor;
      o_fine_step_3072 <= next_step_3072;
      o_coarse_tuning <= prof_rdata[COARSE_TUNE_LSB +: COARSE_W]; // see (R17)
      o_fine_tuning <= fine_field;
      o_fine_shift_down <= !fine_field[FINE_W-1] && (fine_field != '0); // see (R7)
      o_fine_shift_up <= fine_field[FINE_W-1]; // see (R7)
      o_coarse_start_phase <= prof_rdata[COARSE_START_LSB +: COARSE_W];
      o_fine_start_phase <= prof_rdata[FINE_START_LSB +: FINE_START_W]; // see (R10)
      o_phase_load <= i_sysref_sync;
      o_coarse_phase <= next_coarse_phase;
      o_offset_binary <= offset_bin; // see (R11)
      stby_out <= next_stby_out;
    end
  end

  assign o_standby_neg_supply_off = stby_out[STBY_NEG_SUPPLY_BIT];
  assign o_standby_main_pll_off = stby_out[STBY_MAIN_PLL_BIT];
  assign o_standby_link_pll_off = stby_out[STBY_LINK_PLL_BIT];
  assign o_standby_link_tx_off = stby_out[STBY_LINK_TX_BIT];
  assign o_standby_framer_off = stby_out[STANDBY_FRAMER_OFF_BIT];
  assign o_standby_datapath_off = stby_out[STANDBY_DATAPATH_OFF_BIT];
  assign o_standby_digital_clocks_off = stby_out[STANDBY_DIGITAL_CLOCKS_OFF_BIT]; // see (R14)

  ////////////////////////////////////////////////////////////////////////////
  // read-back
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (i_reg_addr)
      // hidden outside calibration: reads as zero
      ADDR_CAL_ABORT: next_rdata = {7'h00, abort_bit & i_cal_busy}; // see (R3)
      ADDR_DECIM: next_rdata = {5'h00, decim};
      ADDR_COARSE_TUNE: next_rdata = {2'h0, prof_rdata[COARSE_TUNE_LSB +: COARSE_W]};
      ADDR_FINE_TUNE: next_rdata = fine_field;
      ADDR_COARSE_START: next_rdata = {2'h0, prof_rdata[COARSE_START_LSB +: COARSE_W]};
      ADDR_FINE_START_LOW: next_rdata = prof_rdata[FINE_START_LSB +: 8];
      ADDR_FINE_START_HIGH: next_rdata = {6'h00, prof_rdata[FINE_START_LSB + 8 +: 2]};
      ADDR_OUT_FORMAT: next_rdata = {7'h00, offset_bin};
      ADDR_STANDBY: next_rdata = {1'h0, stby_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : 8'h00;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_abort_two_writes: assert property ((abort_state == AB_ARMED) && wr_cal && !i_reg_wdata[0] // see (R1)
      |=> o_cal_abort && o_cal_cmd_clear ##1 !o_cal_abort)
    else $error("abort sequence did not fire");
  a_abort_hidden_idle: assert property (i_reg_rd && (i_reg_addr == ADDR_CAL_ABORT) && !i_cal_busy // see (R3)
      |=> o_reg_rvalid && (o_reg_rdata == 8'h00))
    else $error("abort register visible outside calibration");
  a_decim_factor_map: assert property ((decim == 3'h3) ##1 (decim == 3'h3) // see (R4) (R6)
      |-> (o_decim_factor == 6'h10) && !o_fine_step_3072)
    else $error("decimation code 3 not mapped to 16");
  a_coarse_write_reach: assert property ((i_reg_wr && (i_reg_addr == ADDR_COARSE_TUNE)) // see (R5) (R17)
      ##1 (!i_reg_wr && $stable(i_profile_sel)) |=> o_coarse_tuning == $past(i_reg_wdata[5:0], 2))
    else $error("coarse tuning write did not reach datapath");
  a_fine_direction: assert property ((!fine_field[7] && (fine_field != 8'h00)) // see (R7)
      |=> o_fine_shift_down && !o_fine_shift_up)
    else $error("positive fine word not shifting down");
  a_sysref_phase_load: assert property (i_sysref_sync // see (R9)
      |=> o_phase_load && (o_coarse_phase == $past(prof_rdata[19:14])))
    else $error("coarse start phase not loaded on sync");
  a_fine_start_join: assert property ($stable(prof_rdata) // see (R10)
      |=> o_fine_start_phase == $past(prof_rdata[29:20]))
    else $error("fine start phase not assembled");
  a_format_follow: assert property ($rose(offset_bin) |=> o_offset_binary) // see (R11)
    else $error("offset binary select not applied");
  a_standby_mask: assert property (!i_standby |=> (stby_out == 7'h00)) // see (R12)
    else $error("block powered down outside standby");
  a_standby_framer: assert property (i_standby && stby_mask[2] |=> o_standby_framer_off) // see (R13)
    else $error("framer not powered down in standby");
  a_digclk_gate: assert property (i_standby && stby_mask[0] |=> o_standby_digital_clocks_off) // see (R14)
    else $error("digital clocks not gated in standby");
  a_finish_clears: assert property (i_cal_finish |=> o_cal_cmd_clear) // see (R15)
    else $error("finish did not clear calibration command");
  a_profile_read: assert property (i_reg_rd && (i_reg_addr == ADDR_FINE_TUNE) // see (R16)
      |=> o_reg_rdata == $past(fine_field))
    else $error("fine tuning read not from selected profile");

  c_abort_fired: cover property (o_cal_abort);
  c_sysref_load: cover property (i_sysref_sync ##1 o_phase_load);
  c_standby_clocks: cover property (o_standby_digital_clocks_off && o_standby_datapath_off);
  c_profile_switch: cover property (!$stable(i_profile_sel) ##2 (o_coarse_tuning != 6'h05));

endmodule // ddc_nco_standby_config

`default_nettype wire

// >>> rtl/profile_word_store.sv
// per-profile storage of oscillator tuning and start phase words
// assumes one write and one read port on the same clock; read data registered
`timescale 1ns/10ps
`default_nettype none

module profile_word_store #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter logic [WIDTH-1:0] RST_FIRST = '0,
  parameter logic [WIDTH-1:0] RST_REST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // write port
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // read port
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  // write-first so a merge in the next cycle sees the fresh word
  always_comb begin
    if (i_wr && (i_waddr == i_raddr)) begin
      next_rdata = i_wdata;
    end else begin
      next_rdata = mem[i_raddr];
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          mem[g] <= (g == 0) ? RST_FIRST : RST_REST;
        end else if (i_wr && (i_waddr == AW'(g))) begin
          mem[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= RST_FIRST;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // profile_word_store

`default_nettype wire
